/* File: qdc_pkg.sv */
package qdc_pkg;
  localparam int QDC_NCH = 4;
  localparam int QDC_DW = 16;
  localparam int QDC_FRAME_W = 24;
  // command field position within the frame
  localparam int QDC_CMD_MSB = 23;
  localparam int QDC_CMD_LSB = 20;
  localparam int QDC_ADDR_MSB = 19;
  localparam int QDC_ADDR_LSB = 16;
  localparam int QDC_DATA_MSB = 15;
  localparam int QDC_DATA_LSB = 0;
  localparam int QDC_MASK_MSB = 3;
  localparam int QDC_MASK_LSB = 0;
  localparam logic [3:0] QDC_CMD_WR_IN = 4'h1;
  localparam logic [3:0] QDC_CMD_UPD = 4'h2;
  localparam logic [3:0] QDC_CMD_WR_UPD = 4'h3;
  localparam logic [3:0] QDC_CMD_MASK = 4'h5;
  localparam logic [3:0] QDC_CMD_SWRST = 4'h6;
  localparam logic [3:0] QDC_MASK_RST = 4'h0;
  localparam logic [15:0] QDC_ZERO_CODE = 16'h0000;
  localparam logic [15:0] QDC_MID_CODE = 16'h8000;
  // cycles of internal power-on sequence after the reset pin releases
  localparam int QDC_POR_CYCLES = 8;
  localparam logic [3:0] QDC_POR_CNT_W4 = 4'h8;
  typedef enum logic [1:0] {QDC_WAIT, QDC_INIT, QDC_RUN} qdc_state_t;
endpackage

/* File: qdc_edge.sv */
`timescale 1ns/1ps
module qdc_edge
  import qdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  output logic fall_o,
  output logic level_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign fall_o = s3_r & ~s2_r;
  assign level_o = s2_r;
endmodule

/* File: qdc_chan.sv */
`timescale 1ns/1ps
module qdc_chan
  import qdc_pkg::*;
#(
  parameter int DW = QDC_DW
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic [DW-1:0] clr_val_i,
  input wire logic wr_in_i,
  input wire logic load_i,
  input wire logic wr_dac_i,
  input wire logic [DW-1:0] data_i,
  output logic [DW-1:0] in_o,
  output logic [DW-1:0] dac_o
);
  logic [DW-1:0] in_r;
  logic [DW-1:0] dac_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_r <= '0;
      dac_r <= '0;
    end else if (clr_i) begin
      in_r <= clr_val_i;
      dac_r <= clr_val_i;
    end else begin
      if (wr_in_i) begin
        in_r <= data_i;
      end
      if (wr_dac_i) begin
        dac_r <= data_i;
      end else if (load_i) begin
        dac_r <= in_r;
      end
    end
  end
  assign in_o = in_r;
  assign dac_o = dac_r;
endmodule

/* File: qdc_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - command 0101 loads mask from DB3..DB0
// - mask bits DB3..DB0 map channels D..A
// - mask resets to zero
// - masked channel sees load pin high
// - load pin falling edge updates unmasked channels
// - load pin held low ignores mask
// - 0001 writes input, DAC if pin low
// - 0010 copies input into DAC
// - 0011 writes input and DAC
// - reset pin clears to zero or midscale
// - no updates while reset pin low
// - 0110 software reset to power-on code
// - load pin ignored during power-on reset
// - reset pin low delays initialization
// - power-up level chosen by select pin
// - outputs hold until valid write or load pin falling edge
// - command in frame bits 23..20
// - 0001 with pin low updates at frame end
module qdc_ctrl
  import qdc_pkg::*;
#(
  parameter int DW = QDC_DW
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic RESET_N_I,
  input wire logic RESET_LEVEL_SELECT_I,
  input wire logic DAC_LOAD_STROBE_N_I,
  input wire logic FRAME_VALID_I,
  input wire logic [QDC_FRAME_W-1:0] FRAME_I,
  output logic [QDC_NCH*DW-1:0] DAC_CODE_O,
  output logic [QDC_NCH*DW-1:0] INPUT_CODE_O,
  output logic [QDC_NCH-1:0] LOAD_MASK_O,
  output logic READY_O
);
  qdc_state_t state_r;
  qdc_state_t state_nxt;
  logic [3:0] por_cnt_r;
  logic [QDC_NCH-1:0] mask_r;
  logic rst_s1_r;
  logic rst_s2_r;
  logic sel_r;
  logic ld_fall;
  logic ld_level;
  logic run;
  logic frame_ok;
  logic [3:0] cmd;
  logic [3:0] addr;
  logic [DW-1:0] data;
  logic cmd_wr_in;
  logic cmd_upd;
  logic cmd_wr_upd;
  logic cmd_mask;
  logic cmd_swrst;
  logic clr;
  logic [DW-1:0] clr_val;

  qdc_edge u_edge (
    .clk_i(REF_CLK_I),
    .nrst_i(NRST_I),
    .pin_i(DAC_LOAD_STROBE_N_I),
    .fall_o(ld_fall),
    .level_o(ld_level)
  );

  // reset pin synchroniser; only the second stage is used
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= RESET_N_I;
      rst_s2_r <= rst_s1_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      QDC_WAIT: if (rst_s2_r) state_nxt = QDC_INIT;
      QDC_INIT: if (por_cnt_r == QDC_POR_CNT_W4) state_nxt = QDC_RUN;
      QDC_RUN: if (cmd_swrst) state_nxt = QDC_INIT;
    endcase
    if (!rst_s2_r) begin
      state_nxt = QDC_WAIT;
    end
  end

  // strap sampled on clock, not under async reset
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_r <= QDC_WAIT;
      por_cnt_r <= 4'h0;
      sel_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      por_cnt_r <= (state_r == QDC_INIT) ? por_cnt_r + 4'h1 : 4'h0;
      sel_r <= RESET_LEVEL_SELECT_I;
    end
  end

  assign run = (state_r == QDC_RUN) && rst_s2_r;
  assign cmd = FRAME_I[QDC_CMD_MSB:QDC_CMD_LSB];
  assign addr = FRAME_I[QDC_ADDR_MSB:QDC_ADDR_LSB];
  assign data = FRAME_I[QDC_DATA_MSB:QDC_DATA_LSB];
  assign frame_ok = FRAME_VALID_I && run;
  assign cmd_wr_in = frame_ok && (cmd == QDC_CMD_WR_IN);
  assign cmd_upd = frame_ok && (cmd == QDC_CMD_UPD);
  assign cmd_wr_upd = frame_ok && (cmd == QDC_CMD_WR_UPD);
  assign cmd_mask = frame_ok && (cmd == QDC_CMD_MASK);
  assign cmd_swrst = frame_ok && (cmd == QDC_CMD_SWRST);
  assign clr = (state_r != QDC_RUN) || !rst_s2_r;
  assign clr_val = sel_r ? QDC_MID_CODE[DW-1:0] : QDC_ZERO_CODE[DW-1:0];

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mask_r <= QDC_MASK_RST;
    end else if (clr) begin
      mask_r <= QDC_MASK_RST;
    end else if (cmd_mask) begin
      mask_r <= FRAME_I[QDC_MASK_MSB:QDC_MASK_LSB];
    end
  end

  genvar g;
  generate
    for (g = 0; g < QDC_NCH; g++) begin : g_ch
      logic sel;
      logic wr_in;
      logic wr_dac;
      logic load;
      assign sel = (addr[g] == 1'b1);
      // input write, DAC if pin low
      // same frame update when pin low
      assign wr_in = sel && (cmd_wr_in || cmd_wr_upd);
      assign wr_dac = sel && (cmd_wr_upd || (cmd_wr_in && !ld_level));
      // bit g is channel g (A..D)
      assign load = run && ((ld_fall && !mask_r[g]) || (sel && cmd_upd));
      qdc_chan #(.DW(DW)) u_ch (
        .clk_i(REF_CLK_I),
        .nrst_i(NRST_I),
        .clr_i(clr),
        .clr_val_i(clr_val),
        .wr_in_i(wr_in),
        .load_i(load),
        .wr_dac_i(wr_dac),
        .data_i(data),
        .in_o(INPUT_CODE_O[g*DW +: DW]),
        .dac_o(DAC_CODE_O[g*DW +: DW])
      );
    end
  endgenerate

  assign LOAD_MASK_O = mask_r;
  assign READY_O = run;

  // assertions
  sequence init_start_s;
    (state_r == QDC_WAIT) ##1 (state_r == QDC_INIT);
  endsequence
  sequence swrst_s;
    cmd_swrst ##1 (state_r == QDC_INIT);
  endsequence
  hold_out_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (run && $past(run) && !FRAME_VALID_I && !ld_fall)
    |=> $stable(DAC_CODE_O))
    else $error("dac codes changed without cause");
  mask_load_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    cmd_mask
    |=> (LOAD_MASK_O == $past(FRAME_I[QDC_MASK_MSB:QDC_MASK_LSB])))
    else $error("mask not loaded");
  mask_reset_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    clr
    |=> (LOAD_MASK_O == QDC_MASK_RST))
    else $error("mask not cleared");
  clear_level_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (!rst_s2_r ##1 !rst_s2_r)
    |-> (DAC_CODE_O[DW-1:0] == $past(clr_val)))
    else $error("channel a not at clear level");
  no_run_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    !rst_s2_r
    |=> !READY_O)
    else $error("ready during reset pin");
  swrst_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    cmd_swrst
    |=> !READY_O [*8])
    else $error("software reset too short");
  upd_copy_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (cmd_upd && addr[0] && !cmd_wr_upd)
    |=> (DAC_CODE_O[DW-1:0] == $past(INPUT_CODE_O[DW-1:0])))
    else $error("copy to dac a failed");
  wr_upd_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (cmd_wr_upd && addr[0])
    |=> (DAC_CODE_O[DW-1:0] == $past(data)))
    else $error("write and update failed");
  masked_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (run && mask_r[0] && !FRAME_VALID_I && $past(run))
    |=> $stable(DAC_CODE_O[DW-1:0]))
    else $error("masked channel updated");
  load_ch_a_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (run && ld_fall && !mask_r[0] && !FRAME_VALID_I)
    |=> (DAC_CODE_O[0 +: DW] == $past(INPUT_CODE_O[0 +: DW])))
    else $error("pin load missed on channel a");
  load_ch_b_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (run && ld_fall && !mask_r[1] && !FRAME_VALID_I)
    |=> (DAC_CODE_O[DW +: DW] == $past(INPUT_CODE_O[DW +: DW])))
    else $error("pin load missed on channel b");
  load_ch_c_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (run && ld_fall && !mask_r[2] && !FRAME_VALID_I)
    |=> (DAC_CODE_O[2*DW +: DW] == $past(INPUT_CODE_O[2*DW +: DW])))
    else $error("pin load missed on channel c");
  load_ch_d_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (run && ld_fall && !mask_r[3] && !FRAME_VALID_I)
    |=> (DAC_CODE_O[3*DW +: DW] == $past(INPUT_CODE_O[3*DW +: DW])))
    else $error("pin load missed on channel d");
  masked_b_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (run && mask_r[1] && !FRAME_VALID_I)
    |=> $stable(DAC_CODE_O[DW +: DW]))
    else $error("masked channel b updated");
  masked_c_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (run && mask_r[2] && !FRAME_VALID_I)
    |=> $stable(DAC_CODE_O[2*DW +: DW]))
    else $error("masked channel c updated");
  masked_d_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (run && mask_r[3] && !FRAME_VALID_I)
    |=> $stable(DAC_CODE_O[3*DW +: DW]))
    else $error("masked channel d updated");
  wr_in_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (cmd_wr_in && addr[0])
    |=> (INPUT_CODE_O[0 +: DW] == $past(data)))
    else $error("input write missed");
  wr_hold_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (cmd_wr_in && addr[0] && ld_level)
    |=> $stable(DAC_CODE_O[0 +: DW]))
    else $error("dac written with pin high");
  wr_low_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (cmd_wr_in && addr[0] && !ld_level)
    |=> (DAC_CODE_O[0 +: DW] == $past(data)))
    else $error("dac not written with pin low");
  pin_low_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (cmd_wr_in && addr[0] && !ld_level && mask_r[0])
    |=> (DAC_CODE_O[0 +: DW] == $past(data)))
    else $error("mask blocked write with pin low");
  upd_keep_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    cmd_upd
    |=> $stable(INPUT_CODE_O))
    else $error("copy changed input codes");
  wr_upd_in_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (cmd_wr_upd && addr[0])
    |=> (INPUT_CODE_O[0 +: DW] == $past(data)))
    else $error("write and update missed input");
  swrst_clear_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    swrst_s
    |=> (DAC_CODE_O[0 +: DW] == $past(clr_val)))
    else $error("software reset did not clear");
  wait_hold_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    !rst_s2_r
    |=> (state_r == QDC_WAIT))
    else $error("init started with reset pin low");
  init_len_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    init_start_s
    |-> !READY_O [*8])
    else $error("init too short");
  por_ignore_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (ld_fall && (state_r == QDC_INIT))
    |=> (DAC_CODE_O[0 +: DW] == $past(clr_val)))
    else $error("pin load during init");
  power_level_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    ((state_r == QDC_INIT) ##1 (state_r == QDC_INIT))
    |-> (INPUT_CODE_O[0 +: DW] == $past(clr_val)))
    else $error("input not at power-up level");
  hold_in_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (run && !FRAME_VALID_I)
    |=> $stable(INPUT_CODE_O))
    else $error("input codes changed without cause");
  refuse_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (FRAME_VALID_I && !run)
    |=> (LOAD_MASK_O == QDC_MASK_RST))
    else $error("frame taken while not running");
endmodule

/* File: qdc_host.sv */
`timescale 1ns/1ps
module qdc_host
  import qdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic send_i,
  input wire logic [QDC_FRAME_W-1:0] word_i,
  output logic valid_o,
  output logic [QDC_FRAME_W-1:0] frame_o
);
  // command sits in the top nibble of the word
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      valid_o <= 1'b0;
      frame_o <= 24'h000000;
    end else if (send_i) begin
      valid_o <= 1'b1;
      frame_o <= word_i;
    end else begin
      valid_o <= 1'b0;
      // released lines flip, so a stale frame never looks valid
      frame_o <= ~frame_o;
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  import qdc_pkg::*;
  logic clk = 0, nrst = 0, rst_n = 1, sel = 0, ld_n = 1, send = 0;
  logic fv, rdy;
  logic [23:0] word = 0, fr;
  logic [63:0] dac, inp;
  logic [3:0] msk, em;
  logic [3:0][15:0] ei, ed;
  logic [31:0] r;
  logic [3:0] cmds [6] = '{QDC_CMD_WR_IN, QDC_CMD_UPD, QDC_CMD_WR_UPD,
    QDC_CMD_MASK, QDC_CMD_WR_IN, QDC_CMD_WR_UPD};
  int miscompares = 0, check_count = 0, seed = 14;
  qdc_host qdc_host_i(.clk_i(clk), .nrst_i(nrst), .send_i(send),
    .word_i(word), .valid_o(fv), .frame_o(fr));
  qdc_ctrl qdc_ctrl_i(.REF_CLK_I(clk), .NRST_I(nrst), .RESET_N_I(rst_n),
    .RESET_LEVEL_SELECT_I(sel), .DAC_LOAD_STROBE_N_I(ld_n),
    .FRAME_VALID_I(fv), .FRAME_I(fr), .DAC_CODE_O(dac),
    .INPUT_CODE_O(inp), .LOAD_MASK_O(msk), .READY_O(rdy));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic clear();
    ei = {4{sel ? QDC_MID_CODE : QDC_ZERO_CODE}};
    ed = ei;
    em = QDC_MASK_RST;
  endtask
  task automatic wait_ready();
    repeat (40) if (rdy !== 1'b1) @(posedge clk);
    #1;
  endtask
  task automatic issue(input logic [23:0] w);
    @(posedge clk);
    send <= 1'b1;
    word <= w;
    @(posedge clk);
    send <= 1'b0;
  endtask
  task automatic put(input logic [3:0] c, input logic [3:0] a,
                     input logic [15:0] d);
    issue({c, a, d});
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      if (a[i] && (c == QDC_CMD_WR_IN || c == QDC_CMD_WR_UPD)) ei[i] = d;
      if (a[i] && (c == QDC_CMD_WR_UPD || (c == QDC_CMD_WR_IN && !ld_n)))
        ed[i] = d;
      if (a[i] && c == QDC_CMD_UPD) ed[i] = ei[i];
    end
    if (c == QDC_CMD_MASK) em = d[3:0];
    if (c == QDC_CMD_SWRST) clear();
    wait_ready();
    check(inp, ei);
    check(dac, ed);
    check(msk, em);
  endtask
  task automatic fall();
    @(posedge clk);
    ld_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++) if (!em[i]) ed[i] = ei[i];
    check(dac, ed);
  endtask
  task automatic strobe();
    fall();
    @(posedge clk);
    ld_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    clear();
    wait_ready();
    check(dac, ed);
    check(msk, em);
    for (int k = 0; k < 60; k++) begin
      if (k == 30) fall();
      if (k < 30 && k % 7 == 3) strobe();
      r = $random(seed);
      put(cmds[r[18:16] % 6], r[23:20], r[15:0]);
    end
    @(posedge clk);
    ld_n <= 1'b1;
    repeat (4) @(posedge clk);
    put(QDC_CMD_MASK, 4'h0, 16'h000A);
    put(QDC_CMD_WR_IN, 4'hF, 16'h5A5A);
    strobe();
    @(posedge clk);
    sel <= 1'b1;
    rst_n <= 1'b0;
    issue({QDC_CMD_WR_UPD, 4'hF, 16'h1234});
    repeat (4) @(posedge clk);
    clear();
    #1;
    check(dac, ed);
    check(rdy, 1'b0);
    rst_n <= 1'b1;
    wait_ready();
    check(dac, ed);
    sel <= 1'b0;
    put(QDC_CMD_WR_UPD, 4'h3, 16'h7777);
    put(QDC_CMD_SWRST, 4'h0, 16'h0000);
    close_out();
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule
